// >>> src/backplane_paging_passthrough.sv
module backplane_paging_passthrough (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input paging_pkg::pt_cmd_s pt_cmd [2],
  output paging_pkg::pt_ans_s pt_ans [2],
  output logic net_suspend,
  output logic bp_req,
  output paging_pkg::page_hdr_s bp_hdr,
  input wire logic bp_done,
  input wire logic bp_ok,
  output logic health_store,
  output logic [12:0] health_addr,
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [31:0] ctrl; // Enable and page length select
  logic [12:0] in_cnt; // Inbound word count
  logic [12:0] out_cnt; // Outbound word count
  logic [15:0] fail_limit; // Consecutive failures before stopping
  logic [15:0] health_ptr; // Signed health record location
  logic [4:0] irq_status; // Sticky events
  logic [4:0] irq_mask; // Event enables
  logic [15:0] fail_cnt; // Consecutive failed transfers
  logic suspended; // Network traffic stopped
  logic [7:0] in_page; // Current inbound page index
  logic [7:0] out_page; // Current outbound page index
  logic hdr_pt_v; // Exchange in flight carries a pass-through block
  logic [1:0] hdr_pt_idx; // Which function it carries
  paging_pkg::xfer_state_e state; // Exchange sequencer
  paging_pkg::xfer_state_e next_state;
  logic [3:0] pt_owned; // Pass-through ids held by a port
  logic pt_release; // Free the delivered id
  logic [4:0] events; // Events raised this cycle

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Reserved select code falls back to the smallest page
  function automatic logic [7:0] page_len_of(input logic [1:0] sel);
    if (sel == paging_pkg::SIZE_SEL_240) begin
      return paging_pkg::PAGE_LEN_240;
    end else if (sel == paging_pkg::SIZE_SEL_120) begin
      return paging_pkg::PAGE_LEN_120;
    end else begin
      return paging_pkg::PAGE_LEN_60;
    end
  endfunction

  // Pages needed for a count, rounded up
  function automatic logic [7:0] page_total_of(input logic [12:0] cnt, input logic [7:0] len);
    logic [13:0] sum;
    sum = {1'b0, cnt} + {6'h00, len} - 14'h0001;
    return 8'(sum / {6'h00, len});
  endfunction

  // Words in a given page; the last one keeps only the leftover
  function automatic logic [7:0] words_in_page(input logic [7:0] page, input logic [7:0] total,
                                               input logic [12:0] cnt, input logic [7:0] len);
    logic [12:0] first;
    first = 13'(page * len);
    if (total == 8'h00) begin
      return 8'h00;
    end else if (page == total - 8'h01) begin
      return 8'(cnt - first);
    end else begin
      return len;
    end
  endfunction

  // Next page index with wrap after the last page
  function automatic logic [7:0] step_page(input logic [7:0] page, input logic [7:0] total);
    if (total == 8'h00 || page >= total - 8'h01) begin
      return 8'h00;
    end else begin
      return page + 8'h01;
    end
  endfunction

  // Lowest held pass-through id
  function automatic logic [1:0] first_owned(input logic [3:0] bits);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = paging_pkg::PT_FUNCS - 1; i >= 0; i--) begin
      if (bits[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Page arithmetic
  // ----------------------------------------------------------------
  logic [7:0] page_len; // Selected page length
  logic [7:0] in_total; // Inbound pages
  logic [7:0] out_total; // Outbound pages
  logic health_on; // Location is a valid database index

  assign page_len = page_len_of(ctrl[paging_pkg::CTRL_SIZE_LSB +: 2]);
  assign in_total = page_total_of(in_cnt, page_len);
  assign out_total = page_total_of(out_cnt, page_len);
  // Negative locations, -1 included, and too-high ones store nothing
  assign health_on = !health_ptr[15] && (health_ptr <= paging_pkg::HEALTH_MAX);

  // ----------------------------------------------------------------
  // Exchange sequencer
  // ----------------------------------------------------------------
  // A short step state spaces exchanges so counters settle first
  always_comb begin
    next_state = state;
    case (state)
      paging_pkg::XS_IDLE: begin
        if (ctrl[paging_pkg::CTRL_ENABLE_BIT]) begin
          next_state = paging_pkg::XS_XFER;
        end
      end
      paging_pkg::XS_XFER: begin
        if (bp_done) begin
          next_state = paging_pkg::XS_STEP;
        end
      end
      default: begin
        next_state = paging_pkg::XS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= paging_pkg::XS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request held for the whole exchange
  assign bp_req = (state == paging_pkg::XS_XFER);

  // Header captured at the start so it stands still while in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp_hdr <= '0;
      hdr_pt_v <= 1'b0;
      hdr_pt_idx <= 2'h0;
    end else if (state == paging_pkg::XS_IDLE && next_state == paging_pkg::XS_XFER) begin
      hdr_pt_v <= |pt_owned;
      hdr_pt_idx <= first_owned(pt_owned);
      // Pending pass-through id takes word 0, else the page id
      if (|pt_owned) begin
        bp_hdr.image_id <= paging_pkg::PT_ID_BASE + {14'h0000, first_owned(pt_owned)};
      end else begin
        bp_hdr.image_id <= {8'h00, in_page};
      end
      bp_hdr.in_first <= 13'(in_page * page_len);
      bp_hdr.in_len <= words_in_page(in_page, in_total, in_cnt, page_len);
      bp_hdr.out_id <= {8'h00, out_page};
      bp_hdr.out_first <= 13'(out_page * page_len);
      bp_hdr.out_len <= words_in_page(out_page, out_total, out_cnt, page_len);
      bp_hdr.health <= 1'b1;
    end
  end

  // Pages advance only on success, so a failed page is sent again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_page <= 8'h00;
      out_page <= 8'h00;
    end else if (state == paging_pkg::XS_XFER && bp_done && bp_ok) begin
      in_page <= step_page(in_page, in_total);
      out_page <= step_page(out_page, out_total);
    end
  end

  assign pt_release = (state == paging_pkg::XS_XFER) && bp_done && bp_ok && hdr_pt_v;

  // ----------------------------------------------------------------
  // Failure counting and network suspension
  // ----------------------------------------------------------------
  logic [15:0] fail_inc; // Saturating next failure count
  assign fail_inc = (fail_cnt == 16'hFFFF) ? fail_cnt : fail_cnt + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_cnt <= 16'h0000;
      suspended <= 1'b0;
    end else if (state == paging_pkg::XS_XFER && bp_done) begin
      if (bp_ok) begin
        fail_cnt <= 16'h0000;
        suspended <= 1'b0;
      end else begin
        fail_cnt <= fail_inc;
        // A zero limit never stops traffic
        if (fail_limit != 16'h0000 && fail_inc >= fail_limit) begin
          suspended <= 1'b1;
        end
      end
    end
  end

  assign net_suspend = suspended;

  // ----------------------------------------------------------------
  // Health record store
  // ----------------------------------------------------------------
  // Pulses once per delivered page with the database location
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      health_store <= 1'b0;
      health_addr <= 13'h0000;
    end else begin
      health_store <= (state == paging_pkg::XS_XFER) && bp_done && bp_ok && health_on;
      if (health_on) begin
        health_addr <= health_ptr[12:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pass-through arbitration
  // ----------------------------------------------------------------
  pt_arbiter i_pt_arbiter (
    .pclk(pclk),
    .presetn(presetn),
    .cmd(pt_cmd),
    .suspended(suspended),
    .release_v(pt_release),
    .release_idx(hdr_pt_idx),
    .ans(pt_ans),
    .owned(pt_owned)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    events = 5'h00;
    events[paging_pkg::IRQ_SUSPEND] = state == paging_pkg::XS_XFER && bp_done && !bp_ok &&
                                      !suspended && fail_limit != 16'h0000 &&
                                      fail_inc >= fail_limit;
    events[paging_pkg::IRQ_RESUME] = state == paging_pkg::XS_XFER && bp_done && bp_ok &&
                                     suspended;
    events[paging_pkg::IRQ_BUSY] = pt_ans[0].busy | pt_ans[1].busy;
    events[paging_pkg::IRQ_PT_DONE] = pt_release;
    events[paging_pkg::IRQ_BP_FAIL] = state == paging_pkg::XS_XFER && bp_done && !bp_ok;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic wr_hit; // Write access phase
  logic rd_clear; // Read of the event register completes
  logic addr_ok; // Address is mapped
  logic [31:0] rd_value; // Read mux

  assign wr_hit = psel && penable && pwrite;
  assign rd_clear = psel && penable && !pwrite && paddr == paging_pkg::ADDR_IRQ_STATUS;
  // Zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Sticky events; a read clears only the bits it returned, so an event
  // that lands after the setup-cycle capture is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 5'h00;
    end else begin
      irq_status <= (irq_status & ~(rd_clear ? prdata[4:0] : 5'h00)) | events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= paging_pkg::CTRL_RST;
      in_cnt <= paging_pkg::CNT_RST;
      out_cnt <= paging_pkg::CNT_RST;
      fail_limit <= paging_pkg::FAIL_LIMIT_RST;
      health_ptr <= paging_pkg::HEALTH_NONE;
      irq_mask <= paging_pkg::IRQ_MASK_RST;
    end else if (wr_hit) begin
      if (paddr == paging_pkg::ADDR_CTRL) begin
        ctrl <= {29'h0000_0000, pwdata[2:0]};
      end else if (paddr == paging_pkg::ADDR_IN_CNT) begin
        in_cnt <= pwdata[12:0];
      end else if (paddr == paging_pkg::ADDR_OUT_CNT) begin
        out_cnt <= pwdata[12:0];
      end else if (paddr == paging_pkg::ADDR_FAIL_LIMIT) begin
        fail_limit <= pwdata[15:0];
      end else if (paddr == paging_pkg::ADDR_HEALTH_PTR) begin
        health_ptr <= pwdata[15:0];
      end else if (paddr == paging_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[4:0];
      end
    end
  end

  // Read mux and address check
  always_comb begin
    rd_value = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == paging_pkg::ADDR_CTRL) begin
      rd_value = ctrl;
    end else if (paddr == paging_pkg::ADDR_IN_CNT) begin
      rd_value = {19'h00000, in_cnt};
    end else if (paddr == paging_pkg::ADDR_OUT_CNT) begin
      rd_value = {19'h00000, out_cnt};
    end else if (paddr == paging_pkg::ADDR_FAIL_LIMIT) begin
      rd_value = {16'h0000, fail_limit};
    end else if (paddr == paging_pkg::ADDR_HEALTH_PTR) begin
      rd_value = {16'h0000, health_ptr};
    end else if (paddr == paging_pkg::ADDR_STATUS) begin
      rd_value[paging_pkg::ST_SUSP_BIT] = suspended;
      rd_value[paging_pkg::ST_ACTIVE_BIT] = bp_req;
      rd_value[paging_pkg::ST_PT_LSB +: 4] = pt_owned;
      rd_value[paging_pkg::ST_PAGE_LSB +: 8] = in_page;
      rd_value[paging_pkg::ST_FAIL_LSB +: 16] = fail_cnt;
    end else if (paddr == paging_pkg::ADDR_IRQ_STATUS) begin
      rd_value = {27'h0000000, irq_status};
    end else if (paddr == paging_pkg::ADDR_IRQ_MASK) begin
      rd_value = {27'h0000000, irq_mask};
    end else begin
      addr_ok = 1'b0; // Unmapped: zero data and an error
    end
  end

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_value;
    end
  end

endmodule // backplane_paging_passthrough

// >>> src/paging_pkg.sv
package paging_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00; // Enable and page length select
  localparam logic [7:0] ADDR_IN_CNT = 8'h04; // Inbound word count
  localparam logic [7:0] ADDR_OUT_CNT = 8'h08; // Outbound word count
  localparam logic [7:0] ADDR_FAIL_LIMIT = 8'h0C; // Backplane failure limit
  localparam logic [7:0] ADDR_HEALTH_PTR = 8'h10; // Health record location, signed
  localparam logic [7:0] ADDR_STATUS = 8'h14; // Live state, read only
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18; // Sticky events, cleared by read
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C; // Interrupt enables

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0; // Start backplane paging
  localparam int CTRL_SIZE_LSB = 1; // Two-bit page length select
  localparam int ST_SUSP_BIT = 0; // Network traffic stopped
  localparam int ST_ACTIVE_BIT = 1; // Backplane transfer in flight
  localparam int ST_PT_LSB = 4; // Four pass-through ownership bits
  localparam int ST_PAGE_LSB = 8; // Current inbound page index
  localparam int ST_FAIL_LSB = 16; // Consecutive failure count
  localparam int IRQ_SUSPEND = 0; // Traffic stopped for failures
  localparam int IRQ_RESUME = 1; // Traffic resumed after success
  localparam int IRQ_BUSY = 2; // A port was answered busy
  localparam int IRQ_PT_DONE = 3; // Pass-through block delivered
  localparam int IRQ_BP_FAIL = 4; // One backplane transfer failed
  localparam int IRQ_W = 5;

  // ----------------------------------------------------------------
  // Page lengths and identifiers
  // ----------------------------------------------------------------
  localparam int CNT_W = 13; // Word counts and database indexes
  localparam int PAGE_W = 8; // Page indexes and page lengths
  localparam logic [1:0] SIZE_SEL_60 = 2'h0;
  localparam logic [1:0] SIZE_SEL_120 = 2'h1;
  localparam logic [1:0] SIZE_SEL_240 = 2'h2;
  localparam logic [7:0] PAGE_LEN_60 = 8'h3C;
  localparam logic [7:0] PAGE_LEN_120 = 8'h78;
  localparam logic [7:0] PAGE_LEN_240 = 8'hF0;
  localparam int PT_FUNCS = 4; // Write functions 5, 6, 15, 16 as index 0..3
  localparam logic [15:0] PT_ID_BASE = 16'h26E4; // First pass-through id, 9956
  localparam logic [7:0] BUSY_EXC_CODE = 8'h06; // Slave busy exception
  localparam logic [15:0] HEALTH_NONE = 16'hFFFF; // Location -1: do not store
  localparam logic [15:0] HEALTH_MAX = 16'h134B; // Highest location, 4939

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [12:0] CNT_RST = 13'h0000;
  localparam logic [15:0] FAIL_LIMIT_RST = 16'h0000;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_XFER = 2'b01,
    XS_STEP = 2'b11
  } xfer_state_e;

  // Pass-through request from one serial slave port
  typedef struct packed {
    logic req; // One-cycle pulse
    logic [1:0] func; // Write function index
  } pt_cmd_s;

  // Answer to one serial slave port
  typedef struct packed {
    logic grant; // One-cycle pulse: command accepted
    logic busy; // One-cycle pulse: reply with exception
    logic [7:0] exc_code; // Exception code to send
  } pt_ans_s;

  // Header of one backplane exchange
  typedef struct packed {
    logic [15:0] image_id; // Word 0 of the inbound image
    logic [12:0] in_first; // First inbound word of the page
    logic [7:0] in_len; // Inbound words in the page
    logic [15:0] out_id; // Outbound page id
    logic [12:0] out_first; // First outbound word of the page
    logic [7:0] out_len; // Outbound words in the page
    logic health; // Page refreshes the health record
  } page_hdr_s;

endpackage

// >>> src/pt_arbiter.sv
module pt_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input paging_pkg::pt_cmd_s cmd [2],
  input wire logic suspended,
  input wire logic release_v,
  input wire logic [1:0] release_idx,
  output paging_pkg::pt_ans_s ans [2],
  output logic [3:0] owned
);

  // ----------------------------------------------------------------
  // Ownership decision
  // ----------------------------------------------------------------
  logic [3:0] next_owned; // Ownership after this cycle
  logic [1:0] grant_now; // Ports granted this cycle
  logic [1:0] busy_now; // Ports refused this cycle

  // Port 0 is looked at first, so on a same-cycle tie it counts as earlier
  always_comb begin
    next_owned = owned;
    grant_now = 2'b00;
    busy_now = 2'b00;
    // A delivered block frees its identifier before new claims
    if (release_v) begin
      next_owned[release_idx] = 1'b0;
    end
    for (int p = 0; p < 2; p++) begin
      // Stopped ports carry no traffic, so claims are ignored
      if (cmd[p].req && !suspended) begin
        if (!next_owned[cmd[p].func]) begin
          next_owned[cmd[p].func] = 1'b1;
          grant_now[p] = 1'b1;
        end else begin
          busy_now[p] = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State and answers
  // ----------------------------------------------------------------
  // One owner per identifier; the holder is the port that claimed first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owned <= 4'h0;
    end else begin
      owned <= next_owned;
    end
  end

  // Registered answers so the ports see clean pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        ans[p] <= '0;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        ans[p].grant <= grant_now[p];
        ans[p].busy <= busy_now[p];
        ans[p].exc_code <= busy_now[p] ? paging_pkg::BUSY_EXC_CODE : 8'h00;
      end
    end
  end

endmodule // pt_arbiter

// >>> dv/backplane_paging_passthrough_chk.sv
module backplane_paging_passthrough_chk (
  input wire logic pclk,
  input wire logic presetn,
  input paging_pkg::pt_cmd_s pt_cmd [2],
  input paging_pkg::pt_ans_s pt_ans [2],
  input wire logic net_suspend,
  input wire logic bp_req,
  input paging_pkg::page_hdr_s bp_hdr,
  input wire logic bp_done,
  input wire logic bp_ok,
  input wire logic health_store,
  input wire logic [12:0] health_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Port answers, traffic stop, paging, health record
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_busy_code: assert property (pt_ans[1].busy |-> pt_ans[1].exc_code == 8'h06)
    else $error("busy answer without code six");
  a_answer_one: assert property (pt_cmd[0].req && !net_suspend |=> pt_ans[0].grant != pt_ans[0].busy)
    else $error("claim not answered once");
  a_tie_port0: assert property (pt_cmd[0].req && pt_cmd[1].req && pt_cmd[0].func == pt_cmd[1].func
    && !net_suspend |=> !pt_ans[1].grant)
    else $error("later port also granted");
  a_quiet_stop: assert property (net_suspend && pt_cmd[1].req |=> !pt_ans[1].grant && !pt_ans[1].busy)
    else $error("answer while traffic stopped");
  a_stop_cause: assert property ($rose(net_suspend) |-> $past(bp_done) && !$past(bp_ok))
    else $error("stop without failed exchange");
  a_resume_now: assert property (net_suspend && bp_done && bp_ok |=> !net_suspend)
    else $error("no resume after success");
  a_page_max: assert property (bp_req |-> bp_hdr.in_len <= 8'hF0 && bp_hdr.out_len <= 8'hF0)
    else $error("page longer than 240");
  a_health_rng: assert property (health_store |-> health_addr <= 13'h134B)
    else $error("health location out of range");
  a_health_cause: assert property (health_store |-> $past(bp_done))
    else $error("health store without page");
  a_step_gap: assert property ($fell(bp_req) |-> !bp_req [*2])
    else $error("next page too soon");
  // Main scenarios reached
  c_busy: cover property (pt_ans[1].busy);
  c_stop: cover property ($rose(net_suspend));
  c_store: cover property (health_store);
endmodule // backplane_paging_passthrough_chk

bind backplane_paging_passthrough backplane_paging_passthrough_chk i_chk (.pclk, .presetn,
  .pt_cmd, .pt_ans, .net_suspend, .bp_req, .bp_hdr, .bp_done, .bp_ok, .health_store,
  .health_addr);

// >>> dv/bp_partner.sv
module bp_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bp_req,
  input wire logic [3:0] delay,
  input wire logic fail,
  output logic bp_done,
  output logic bp_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt; // Cycles spent on the current exchange
  // Processor side: takes each page after a delay, then answers once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      bp_done <= 1'b0;
      bp_ok <= 1'b0;
    end else if (bp_req && !bp_done && wait_cnt >= delay) begin
      bp_done <= 1'b1; // Page filed or loaded by page id
      bp_ok <= !fail;
      wait_cnt <= 4'h0;
    end else begin
      bp_done <= 1'b0;
      bp_ok <= ~bp_ok; // Meaningless without done, so never steady
      wait_cnt <= bp_req ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // bp_partner

// >>> dv/backplane_paging_passthrough_bench.sv
module backplane_paging_passthrough_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic net_suspend, bp_req, bp_done, bp_ok, health_store, irq, fail;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] health_addr;
  paging_pkg::pt_cmd_s pt_cmd [2];
  paging_pkg::pt_ans_s pt_ans [2];
  paging_pkg::page_hdr_s bp_hdr;
  int err_total, cmp_count, hs_cnt, n0, len, tot, idx;
  backplane_paging_passthrough i_backplane_paging_passthrough (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pt_cmd, .pt_ans,
    .net_suspend, .bp_req, .bp_hdr, .bp_done, .bp_ok, .health_store, .health_addr, .irq);
  bp_partner i_bp_partner (.pclk, .presetn, .bp_req, .delay(4'h3), .fail, .bp_done, .bp_ok);
  // ----------------------------------------------------------------
  // Clock, monitors and tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Store pulses counted mid-cycle, where they are settled
  always @(negedge pclk) if (health_store === 1'b1) hs_cnt++;
  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; data and error taken at the committing edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      report_and_stop();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for the start of the next exchange, bounded
  task automatic next_xfer();
    int n;
    @(negedge pclk);
    for (n = 0; n < 99 && bp_req === 1'b1; n++) @(negedge pclk);
    for (n = n; n < 99 && bp_req !== 1'b1; n++) @(negedge pclk);
    if (n == 99) begin
      err_total++;
      report_and_stop();
    end
  endtask
  // Both ports may claim function index 1 in the same cycle
  task automatic claim(input logic r0, input logic r1, input logic [11:0] exp);
    @(posedge pclk);
    pt_cmd[0] <= '{r0, 2'h1};
    pt_cmd[1] <= '{r1, 2'h1};
    @(posedge pclk);
    pt_cmd[0].req <= 1'b0;
    pt_cmd[1].req <= 1'b0;
    @(negedge pclk);
    chk(32'({pt_ans[0].grant, pt_ans[0].busy, pt_ans[1].grant, pt_ans[1].busy,
      pt_ans[1].exc_code}), 32'(exp));
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, fail} = '0;
    paddr = '0;
    pwdata = '0;
    pt_cmd[0] = '0;
    pt_cmd[1] = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, paging_pkg::ADDR_HEALTH_PTR, '0);
    chk(rd, 32'h0000FFFF);
    apb(1'b0, 8'h20, '0);
    chk({rd[30:0], rerr}, 32'h1);
    apb(1'b1, paging_pkg::ADDR_IN_CNT, 32'h82); // Within 480-word arrays
    apb(1'b1, paging_pkg::ADDR_OUT_CNT, 32'hF0);
    apb(1'b1, paging_pkg::ADDR_FAIL_LIMIT, 32'h2);
    apb(1'b1, paging_pkg::ADDR_HEALTH_PTR, 32'h5);
    // Each page length over 130 words; two starts skipped after a change
    for (int s = 0; s < 3; s++) begin
      len = 60 << s;
      tot = (130 + len - 1) / len;
      apb(1'b1, paging_pkg::ADDR_CTRL, 32'(2 * s + 1));
      repeat (2) next_xfer();
      idx = bp_hdr.image_id;
      repeat (4) begin
        next_xfer();
        idx = (idx + 1) % tot;
        n0 = (idx == tot - 1) ? 130 - idx * len : len;
        chk({bp_hdr.image_id, bp_hdr.in_len, bp_hdr.out_len},
          {16'(idx), 8'(n0), 8'(len)});
        chk(32'(bp_hdr.in_first), 32'(idx * len));
      end
    end
    n0 = hs_cnt;
    repeat (2) next_xfer();
    chk(32'(hs_cnt - n0), 32'h2);
    chk(32'(health_addr), 32'h5);
    // Paging halted so the first new page is the one that carries the claim
    apb(1'b1, paging_pkg::ADDR_CTRL, 32'h4);
    repeat (12) @(posedge pclk);
    claim(1'b1, 1'b1, 12'h906);
    claim(1'b0, 1'b1, 12'h106);
    apb(1'b1, paging_pkg::ADDR_IRQ_MASK, 32'h1F);
    @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, paging_pkg::ADDR_IRQ_MASK, 32'h0);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b0, paging_pkg::ADDR_IRQ_STATUS, '0);
    chk(rd & 32'h4, 32'h4);
    apb(1'b0, paging_pkg::ADDR_IRQ_STATUS, '0);
    chk(rd & 32'h4, 32'h0);
    apb(1'b1, paging_pkg::ADDR_CTRL, 32'h5);
    next_xfer();
    chk(32'(bp_hdr.image_id), 32'h26E5);
    next_xfer();
    chk(32'(bp_hdr.image_id), 32'h0);
    claim(1'b0, 1'b1, 12'h200);
    // Failing exchanges: stop at the limit, resume on one success
    @(posedge pclk);
    fail <= 1'b1;
    repeat (3) next_xfer();
    chk(32'(net_suspend), 32'h1);
    claim(1'b1, 1'b1, 12'h000);
    @(posedge pclk);
    fail <= 1'b0;
    repeat (2) next_xfer();
    chk(32'(net_suspend), 32'h0);
    apb(1'b1, paging_pkg::ADDR_FAIL_LIMIT, '0);
    fail <= 1'b1;
    repeat (4) next_xfer();
    chk(32'(net_suspend), 32'h0);
    @(posedge pclk);
    fail <= 1'b0;
    apb(1'b1, paging_pkg::ADDR_HEALTH_PTR, 32'hFFFF);
    next_xfer();
    n0 = hs_cnt;
    repeat (2) next_xfer();
    chk(32'(hs_cnt - n0), 32'h0);
    report_and_stop();
  end
endmodule // backplane_paging_passthrough_bench
